// *** rdsd_pkg.sv ***
// Constants and types shared by the block decoder register files
package rdsd_pkg;
   // ------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [15:0] IDX_STATUS = 16'h6000;
   localparam logic [15:0] IDX_LAST_DATA = 16'h6001;
   localparam logic [15:0] IDX_PREV_DATA = 16'h6002;
   localparam logic [15:0] IDX_COUNTERS = 16'h6003;
   localparam logic [15:0] IDX_SETTINGS = 16'h6004;
   localparam logic [15:0] IDX_CONTROL = 16'h6005;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h6006;
   localparam logic [15:0] IDX_IRQ_MASK = 16'h6007;
   localparam int unsigned ADDR_W = 18;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned STAT_SYNC_BIT = 7;
   localparam int unsigned STAT_OVF_BIT = 6;
   localparam int unsigned STAT_RST_BIT = 5;
   localparam int unsigned IDENT_LSB = 2;
   localparam int unsigned ERR_LSB = 0;
   localparam int unsigned SET_CORR_LSB = 13;
   localparam int unsigned SET_GOOD_LSB = 7;
   localparam int unsigned SET_EACC_BIT = 6;
   localparam int unsigned SET_BAD_LSB = 0;
   localparam int unsigned CNT_BAD_LSB = 10;
   localparam int unsigned CNT_GOOD_LSB = 5;
   localparam int unsigned CTR_CLKOUT_BIT = 9;
   localparam int unsigned CTR_CLKIN_BIT = 8;
   localparam int unsigned CTR_ACC_LSB = 6;
   localparam int unsigned CTR_NEWSYNC_BIT = 5;
   localparam int unsigned IRQ_SYNC_BIT = 0;
   localparam int unsigned IRQ_OVF_BIT = 1;
   localparam int unsigned IRQ_RST_BIT = 2;
   localparam int unsigned IRQ_LOST_BIT = 3;
   // ------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------
   localparam logic [15:0] SET_RESET = 16'h1020;
   localparam logic [15:0] CTR_RESET = 16'h0100;
   localparam logic [2:0] IDENT_RESET = 3'h7;
   localparam logic [5:0] LIMIT_RESET = 6'h20;
   localparam logic [2:0] E_IDENT = 3'h4;
   localparam logic [2:0] A_IDENT = 3'h0;
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_BURST2 = 2'h1;
   localparam logic [1:0] ERR_BURST5 = 2'h2;
   localparam logic [1:0] ERR_UNCORR = 2'h3;
   localparam logic [1:0] ACC_STANDARD = 2'h0;
   localparam logic [1:0] ACC_FAST_PI = 2'h1;
   localparam logic [1:0] ACC_REDUCED = 2'h2;
   localparam logic [1:0] ACC_BYPASS = 2'h3;
   localparam logic [1:0] PIN_FORBIDDEN = 2'h3;
   typedef enum logic {RDSD_HUNT, RDSD_LOCKED} rdsd_sync_t;
endpackage

// *** rdsd_blk_if.sv ***
// Block event bundle passed from the register front to its helpers
`timescale 1ns/1ps
interface rdsd_blk_if;
   logic valid;
   logic good;
   logic store;
   logic [15:0] word;
   logic [2:0] ident;
   logic [1:0] err;
   modport src (output valid, good, store, word, ident, err);
   modport dst (input valid, good, store, word, ident, err);
endinterface

// *** rdsd_store.sv ***
// Last and previous block holding registers
`timescale 1ns/1ps
module rdsd_store
   import rdsd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Block events
   rdsd_blk_if.dst blk,
   // Held values
   output logic [15:0] last_word,
   output logic [2:0] last_ident,
   output logic [1:0] last_err,
   output logic [15:0] prev_word,
   output logic [2:0] prev_ident,
   output logic [1:0] prev_err
);
   // Shift last into previous, then load the new block
   always_ff @(posedge clk) begin
      if (!resetn) begin
         last_word <= 16'h0000;
         last_ident <= IDENT_RESET;
         last_err <= ERR_NONE;
         prev_word <= 16'h0000;
         prev_ident <= IDENT_RESET;
         prev_err <= ERR_NONE;
      end else if (blk.store) begin
         prev_word <= last_word;
         prev_ident <= last_ident;
         prev_err <= last_err;
         last_word <= blk.word;
         last_ident <= blk.ident;
         last_err <= blk.err;
      end
   end

   property p_shift;
      @(posedge clk) disable iff (!resetn)
      blk.store |=> (prev_word == $past(last_word)) && (last_word == $past(blk.word));
   endproperty
   chk_prev_takes_last: assert property (p_shift) else $error("previous block not shifted from last");
   chk_word_held: assert property (@(posedge clk) disable iff (!resetn)
      !blk.store |=> $stable(last_word) && $stable(prev_word)) else $error("block words changed without store");
endmodule

// *** rdsd_sync.sv ***
// Block counters and synchronisation tracking
`timescale 1ns/1ps
module rdsd_sync
   import rdsd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Block events and limits
   rdsd_blk_if.dst blk,
   input wire logic restart,
   input wire logic [5:0] good_limit,
   input wire logic [5:0] bad_limit,
   // Results
   output logic locked,
   output logic [5:0] good_cnt,
   output logic [5:0] bad_cnt,
   output wire logic found,
   output wire logic lost
);
   rdsd_sync_t state;
   wire logic good_wrap;
   wire logic bad_hit;
   // Good limit closes a counting window; bad limit ends sync
   assign good_wrap = blk.valid && blk.good && (good_cnt + 6'h01 >= good_limit);
   assign bad_hit = blk.valid && !blk.good && (bad_cnt + 6'h01 >= bad_limit);
   assign found = (state == RDSD_HUNT) && blk.valid && blk.good && !restart;
   assign lost = (state == RDSD_LOCKED) && bad_hit && !restart;
   assign locked = (state == RDSD_LOCKED);

   // Hunt for a good block, then count until too many bad ones
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= RDSD_HUNT;
      end else begin
         case (state)
            RDSD_HUNT: if (found) state <= RDSD_LOCKED;
            RDSD_LOCKED: if (lost || restart) state <= RDSD_HUNT;
            default: state <= RDSD_HUNT;
         endcase
      end
   end

   // Counters restart on each window edge and on loss of sync
   always_ff @(posedge clk) begin
      if (!resetn || restart || lost || good_wrap || state == RDSD_HUNT) begin
         good_cnt <= 6'h00;
         bad_cnt <= 6'h00;
      end else if (blk.valid) begin
         if (blk.good) good_cnt <= good_cnt + 6'h01;
         else bad_cnt <= bad_cnt + 6'h01;
      end
   end

   chk_lost_on_bad_limit: assert property (@(posedge clk) disable iff (!resetn)
      lost |=> !locked && bad_cnt == 6'h00) else $error("sync kept after bad limit");
   chk_good_window: assert property (@(posedge clk) disable iff (!resetn)
      locked && good_wrap && !restart |=> good_cnt == 6'h00) else $error("good counter not restarted");
endmodule

// *** rdsd_regs.sv ***
// Block decoder register front: APB slave, status, counters and interrupt
// How it works
// - Two-bit field picks four decoder access modes
// - Burst field sets correction: off, 2, 5
// - Six-bit good-block loss limit, reset 100000
// - Six-bit bad-block loss limit, reset 100000
// - Settings bit six accepts type E blocks
// - Counter register shows bad, good-count MSBs
// - Counter register shows previous ident and error
// - Status shows last ident and error code
// - Read-only previous block word, reset zero
// - Read-only last block word, reset zero
// - Status flags: sync, overflow, restart seen
// - Pin clock select picks interface mode
`timescale 1ns/1ps
module rdsd_regs
   import rdsd_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [rdsd_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output wire logic PREADY,
   output wire logic PSLVERR,
   // Received blocks from the demodulator path
   input wire logic BLK_VALID,
   input wire logic [15:0] BLK_WORD,
   input wire logic [2:0] BLK_IDENT,
   input wire logic [1:0] BLK_ERR,
   input wire logic RESTART,
   // Mode outputs to the decoder core and pin logic
   output wire logic [1:0] ACCESS_MODE,
   output wire logic [1:0] PIN_MODE,
   output wire logic BYPASS,
   // Interrupt
   output wire logic IRQ
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [15:0] settings;
   logic [15:0] control;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic sync_found;
   logic overrun_flag;
   logic restart_seen;
   logic last_unread;
   logic new_sync_req;
   logic locked;
   logic found;
   logic lost;
   logic [5:0] good_block_count;
   logic [5:0] bad_block_count;
   logic [15:0] last_block_word;
   logic [2:0] last_block_ident;
   logic [1:0] last_block_err;
   logic [15:0] prev_block_word;
   logic [2:0] prev_block_ident;
   logic [1:0] prev_block_err;
   rdsd_blk_if blk ();

   // ------------------------------------------------------------
   // Field decode
   // ------------------------------------------------------------
   wire logic [1:0] burst_correction_mode = settings[SET_CORR_LSB+1:SET_CORR_LSB];
   wire logic [5:0] good_block_loss_limit = settings[SET_GOOD_LSB+5:SET_GOOD_LSB];
   wire logic e_block_accept = settings[SET_EACC_BIT];
   wire logic [5:0] bad_block_loss_limit = settings[SET_BAD_LSB+5:SET_BAD_LSB];
   wire logic [1:0] decoder_access_mode = control[CTR_ACC_LSB+1:CTR_ACC_LSB];
   wire logic pin_clock_out_sel = control[CTR_CLKOUT_BIT];
   wire logic pin_clock_in_sel = control[CTR_CLKIN_BIT];

   // Mode pins follow the control register; the forbidden pin code falls back to decoder output
   assign ACCESS_MODE = decoder_access_mode;
   assign BYPASS = (decoder_access_mode == ACC_BYPASS);
   assign PIN_MODE = ({pin_clock_out_sel, pin_clock_in_sel} == PIN_FORBIDDEN) ? 2'h0 :
                     {pin_clock_out_sel, pin_clock_in_sel};

   // ------------------------------------------------------------
   // Block qualification
   // ------------------------------------------------------------
   // Correction reach decides whether a flagged block still counts as good
   wire logic corr_off = (burst_correction_mode == 2'h0) || (burst_correction_mode == 2'h3);
   wire logic corr_ok = (BLK_ERR == ERR_NONE) ||
                        (BLK_ERR == ERR_BURST2 && !corr_off) ||
                        (BLK_ERR == ERR_BURST5 && burst_correction_mode == 2'h2);
   wire logic [1:0] eff_err = corr_ok ? BLK_ERR : ERR_UNCORR;
   wire logic e_reject = (BLK_IDENT == E_IDENT) && !e_block_accept;
   wire logic blk_good = corr_ok && !e_reject;
   // Fast PI search keeps only A blocks; reduced mode keeps only good ones
   wire logic mode_keep = (decoder_access_mode == ACC_FAST_PI) ? (BLK_IDENT == A_IDENT) :
                          (decoder_access_mode == ACC_REDUCED) ? blk_good : 1'b1;
   assign blk.valid = BLK_VALID && !BYPASS;
   assign blk.good = blk_good;
   assign blk.store = BLK_VALID && !BYPASS && mode_keep;
   assign blk.word = BLK_WORD;
   assign blk.ident = BLK_IDENT;
   assign blk.err = eff_err;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   rdsd_store u_store (
      .clk(CLK),
      .resetn(RESETN),
      .blk(blk.dst),
      .last_word(last_block_word),
      .last_ident(last_block_ident),
      .last_err(last_block_err),
      .prev_word(prev_block_word),
      .prev_ident(prev_block_ident),
      .prev_err(prev_block_err)
   );

   rdsd_sync u_sync (
      .clk(CLK),
      .resetn(RESETN),
      .blk(blk.dst),
      .restart(RESTART || new_sync_req),
      .good_limit(good_block_loss_limit),
      .bad_limit(bad_block_loss_limit),
      .locked(locked),
      .good_cnt(good_block_count),
      .bad_cnt(bad_block_count),
      .found(found),
      .lost(lost)
   );

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire logic [15:0] idx = PADDR[ADDR_W-1:2];
   wire logic hit_status = (idx == IDX_STATUS);
   wire logic hit_last = (idx == IDX_LAST_DATA);
   wire logic hit_prev = (idx == IDX_PREV_DATA);
   wire logic hit_cnt = (idx == IDX_COUNTERS);
   wire logic hit_set = (idx == IDX_SETTINGS);
   wire logic hit_ctr = (idx == IDX_CONTROL);
   wire logic hit_ist = (idx == IDX_IRQ_STATUS);
   wire logic hit_imk = (idx == IDX_IRQ_MASK);
   wire logic mapped = hit_status | hit_last | hit_prev | hit_cnt | hit_set | hit_ctr | hit_ist | hit_imk;
   wire logic unaligned = (PADDR[1:0] != 2'h0);
   wire logic access = PSEL && PENABLE;
   wire logic setup = PSEL && !PENABLE;
   wire logic bad_addr = !mapped || unaligned;
   wire logic wr = access && PWRITE && !bad_addr;
   wire logic rd = access && !PWRITE && !bad_addr;
   // Read data is latched in the setup cycle, so every access completes in one wait-free cycle
   assign PREADY = 1'b1;
   assign PSLVERR = access && bad_addr;

   // Read values of each register
   wire logic [15:0] status_val = {8'h00, sync_found, overrun_flag, restart_seen,
                                   last_block_ident, last_block_err};
   wire logic [15:0] cnt_val = {bad_block_count, good_block_count[5:1],
                                prev_block_ident, prev_block_err};
   wire logic [15:0] rd_val = hit_status ? status_val :
                              hit_last ? last_block_word :
                              hit_prev ? prev_block_word :
                              hit_cnt ? cnt_val :
                              hit_set ? settings :
                              hit_ctr ? control :
                              hit_ist ? {12'h000, irq_status} :
                              hit_imk ? {12'h000, irq_mask} : 16'h0000;

   // Capture read data at setup so PRDATA comes from a flop
   always_ff @(posedge CLK) begin
      if (!RESETN) PRDATA <= 32'h0000_0000;
      else if (setup && !PWRITE) PRDATA <= (bad_addr ? 32'h0000_0000 : {16'h0000, rd_val});
   end

   // ------------------------------------------------------------
   // Software-written registers
   // ------------------------------------------------------------
   // Bit 15 of settings is unused and always reads zero
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         settings <= SET_RESET;
         control <= CTR_RESET;
         irq_mask <= 4'h0;
      end else if (wr) begin
         if (hit_set) settings <= {1'b0, PWDATA[14:0]};
         if (hit_ctr) control <= {6'h00, PWDATA[9:6], 1'b0, PWDATA[4:0]};
         if (hit_imk) irq_mask <= PWDATA[3:0];
      end
   end

   // New-sync bit acts as a one-cycle command and is never stored
   always_ff @(posedge CLK) begin
      if (!RESETN) new_sync_req <= 1'b0;
      else new_sync_req <= wr && hit_ctr && PWDATA[CTR_NEWSYNC_BIT];
   end

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   // Overflow and restart flags clear on a status read; a new event in that cycle wins
   wire logic rd_status = rd && hit_status;
   wire logic ovf_event = blk.store && last_unread;
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         sync_found <= 1'b0;
         overrun_flag <= 1'b0;
         restart_seen <= 1'b0;
      end else begin
         sync_found <= locked;
         overrun_flag <= ovf_event || (overrun_flag && !rd_status);
         restart_seen <= RESTART || (restart_seen && !rd_status);
      end
   end

   // Last word counts as unread from its store until software reads it
   always_ff @(posedge CLK) begin
      if (!RESETN) last_unread <= 1'b0;
      else last_unread <= blk.store || (last_unread && !(rd && hit_last));
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   wire logic [3:0] irq_events = {lost, RESTART, ovf_event, found};
   wire logic [3:0] irq_clear = (wr && hit_ist) ? PWDATA[3:0] : 4'h0;
   // Sticky bits, write one to clear; a fresh event beats its clear
   always_ff @(posedge CLK) begin
      if (!RESETN) irq_status <= 4'h0;
      else irq_status <= irq_events | (irq_status & ~irq_clear);
   end
   assign IRQ = |(irq_status & irq_mask);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Overwriting an unread last word raises overflow one cycle later
   sequence s_unread_store;
      blk.store && last_unread;
   endsequence
   sequence s_flag_up;
      ##1 overrun_flag;
   endsequence
   chk_overflow_on_overwrite: assert property (@(posedge CLK) disable iff (!RESETN)
      s_unread_store |-> s_flag_up)
      else $error("overflow not raised on unread overwrite");
   chk_no_spurious_ovf: assert property (@(posedge CLK) disable iff (!RESETN)
      !overrun_flag && !ovf_event |=> !overrun_flag)
      else $error("overflow rose without overwrite");
   chk_restart_flag: assert property (@(posedge CLK) disable iff (!RESETN)
      RESTART |=> restart_seen && status_val[STAT_RST_BIT])
      else $error("restart not flagged");

   // Sync flag is the lock state seen one cycle late
   chk_sync_tracks: assert property (@(posedge CLK) disable iff (!RESETN)
      found |=> ##1 sync_found)
      else $error("sync flag late after lock");
   chk_sync_drops: assert property (@(posedge CLK) disable iff (!RESETN)
      !locked |=> !sync_found)
      else $error("sync flag kept without lock");

   // New-sync command: a write, a one-cycle request, then hunting again
   sequence s_newsync_write;
      wr && hit_ctr && PWDATA[CTR_NEWSYNC_BIT];
   endsequence
   sequence s_hunt_again;
      ##1 new_sync_req ##1 !locked;
   endsequence
   chk_newsync_hunts: assert property (@(posedge CLK) disable iff (!RESETN)
      s_newsync_write |-> s_hunt_again)
      else $error("new-sync command did not restart the hunt");

   // Thinning modes must drop what they are not asked to keep
   chk_fast_pi_a_only: assert property (@(posedge CLK) disable iff (!RESETN)
      blk.store && decoder_access_mode == ACC_FAST_PI |-> BLK_IDENT == A_IDENT)
      else $error("non-A block stored in fast search");
   chk_reduced_good_only: assert property (@(posedge CLK) disable iff (!RESETN)
      blk.store && decoder_access_mode == ACC_REDUCED |-> blk_good)
      else $error("bad block stored in reduced mode");
   chk_bypass_no_store: assert property (@(posedge CLK) disable iff (!RESETN)
      BYPASS && BLK_VALID |=> $stable(last_block_word))
      else $error("block stored in bypass");

   // Correction reach and settings fields
   chk_uncorr_when_off: assert property (@(posedge CLK) disable iff (!RESETN)
      blk.store && corr_off && BLK_ERR != ERR_NONE |=> last_block_err == ERR_UNCORR)
      else $error("flagged block kept its code with correction off");
   chk_e_rejected: assert property (@(posedge CLK) disable iff (!RESETN)
      BLK_VALID && BLK_IDENT == E_IDENT && !e_block_accept |-> !blk.good)
      else $error("type E block counted good while rejected");
   chk_set_readback: assert property (@(posedge CLK) disable iff (!RESETN)
      wr && hit_set |=> settings == {1'b0, $past(PWDATA[14:0])})
      else $error("settings write lost");
   chk_pin_never_forbidden: assert property (@(posedge CLK) disable iff (!RESETN)
      PIN_MODE != PIN_FORBIDDEN)
      else $error("forbidden pin mode driven");

   // Events must survive a clear that lands in the same cycle
   chk_irq_sticky: assert property (@(posedge CLK) disable iff (!RESETN)
      |irq_events |=> (irq_status & $past(irq_events)) == $past(irq_events))
      else $error("interrupt event lost to its clear");
endmodule

// *** rdsd_demod_model.sv ***
// Demodulator stand-in that presents received blocks and restart pulses
`timescale 1ns/1ps
module rdsd_demod_model (
   // Clock
   input wire logic clk,
   // Block outputs
   output logic blk_valid,
   output logic [15:0] blk_word,
   output logic [2:0] blk_ident,
   output logic [1:0] blk_err,
   output logic restart
);
   // Idle state at time zero
   initial begin
      blk_valid = 1'b0;
      blk_word = 16'h0000;
      blk_ident = 3'h0;
      blk_err = 2'h0;
      restart = 1'b0;
   end
   // One-cycle block; data lines then flip so stale values never look valid
   task automatic send(input logic [15:0] w, input logic [2:0] id, input logic [1:0] e);
      @(posedge clk);
      blk_valid <= 1'b1;
      blk_word <= w;
      blk_ident <= id;
      blk_err <= e;
      @(posedge clk);
      blk_valid <= 1'b0;
      blk_word <= ~w;
      blk_ident <= ~id;
      blk_err <= ~e;
   endtask
   // One-cycle restart pulse
   task automatic pulse_restart();
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
   endtask
endmodule

// *** rds_block_decoder_regs_tb_top.sv ***
// Self-checking bench for the block decoder register front
`timescale 1ns/1ps
module rds_block_decoder_regs_tb_top;
   import rdsd_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, blk_valid, restart, bypass, irq;
   logic [15:0] blk_word;
   logic [2:0] blk_ident;
   logic [1:0] blk_err, access_mode, pin_mode;
   logic [15:0] rd;
   logic err;
   int num_errors = 0;
   int n_checks = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   rdsd_regs i_rdsd_regs (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .BLK_VALID(blk_valid), .BLK_WORD(blk_word), .BLK_IDENT(blk_ident), .BLK_ERR(blk_err),
      .RESTART(restart), .ACCESS_MODE(access_mode), .PIN_MODE(pin_mode), .BYPASS(bypass), .IRQ(irq));
   rdsd_demod_model i_rdsd_demod_model (.clk(clk), .blk_valid(blk_valid), .blk_word(blk_word),
      .blk_ident(blk_ident), .blk_err(blk_err), .restart(restart));
   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {16'h0000, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata[15:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   // Read a register and compare the masked value
   task automatic rchk(input string name, input logic [15:0] idx, input logic [15:0] m, input logic [15:0] exp);
      apb(1'b0, idx, 16'h0000);
      chk(name, exp, rd & m);
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog: the tests take a few hundred cycles at most
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      test_done();
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rchk("status", IDX_STATUS, 16'hFFFF, 16'h001C);
      chk("mapped error", 16'h0000, {15'h0000, err});
      rchk("last word", IDX_LAST_DATA, 16'hFFFF, 16'h0000);
      rchk("prev word", IDX_PREV_DATA, 16'hFFFF, 16'h0000);
      rchk("counters", IDX_COUNTERS, 16'hFFFF, 16'h001C);
      rchk("settings", IDX_SETTINGS, 16'hFFFF, 16'h1020);
      rchk("control", IDX_CONTROL, 16'hFFFF, 16'h0100);
      chk("irq", 16'h0000, {15'h0000, irq});
      apb(1'b0, 16'h6008, 16'h0000);
      chk("unmapped error", 16'h0001, {15'h0000, err});
      apb(1'b1, IDX_SETTINGS, 16'hFFFF);
      rchk("settings", IDX_SETTINGS, 16'hFFFF, 16'h7FFF);
      apb(1'b1, IDX_SETTINGS, SET_RESET);
      $display("test reset done");
      // Two blocks one idle cycle apart, last one left unread
      i_rdsd_demod_model.send(16'h1234, 3'h0, ERR_NONE);
      i_rdsd_demod_model.send(16'h5678, 3'h1, ERR_NONE);
      repeat (4) @(posedge clk);
      rchk("status", IDX_STATUS, 16'hFFFF, 16'h00C4);
      rchk("status", IDX_STATUS, 16'hFFFF, 16'h0084);
      rchk("last word", IDX_LAST_DATA, 16'hFFFF, 16'h5678);
      rchk("prev word", IDX_PREV_DATA, 16'hFFFF, 16'h1234);
      rchk("prev fields", IDX_COUNTERS, 16'h001F, 16'h0000);
      apb(1'b1, IDX_LAST_DATA, 16'hFFFF);
      rchk("last word", IDX_LAST_DATA, 16'hFFFF, 16'h5678);
      $display("test blocks done");
      // Every correction mode against 2-bit and 5-bit bursts
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, IDX_SETTINGS, SET_RESET | 16'(c << 13));
         i_rdsd_demod_model.send(16'h2000, 3'h2, ERR_BURST2);
         rchk("burst2", IDX_STATUS, 16'h001F, (c == 1 || c == 2) ? 16'h0009 : 16'h000B);
         i_rdsd_demod_model.send(16'h2000, 3'h2, ERR_BURST5);
         rchk("burst5", IDX_STATUS, 16'h001F, (c == 2) ? 16'h000A : 16'h000B);
      end
      $display("test correction done");
      // Every access mode and pin mode, then a block in bypass
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, IDX_CONTROL, 16'((i << 8) | (i << 6)));
         @(posedge clk);
         #1;
         chk("access mode", 16'(i), {14'h0000, access_mode});
         chk("bypass", 16'(i == 3), {15'h0000, bypass});
         chk("pin mode", (i == 3) ? 16'h0000 : 16'(i), {14'h0000, pin_mode});
      end
      i_rdsd_demod_model.send(16'hBEEF, 3'h3, ERR_NONE);
      rchk("last word", IDX_LAST_DATA, 16'hFFFF, 16'h2000);
      apb(1'b1, IDX_CONTROL, 16'h0140);
      i_rdsd_demod_model.send(16'h6000, 3'h2, ERR_NONE);
      i_rdsd_demod_model.send(16'h6100, A_IDENT, ERR_NONE);
      rchk("fast search", IDX_PREV_DATA, 16'hFFFF, 16'h2000);
      apb(1'b1, IDX_CONTROL, 16'h0180);
      i_rdsd_demod_model.send(16'h6200, 3'h1, ERR_UNCORR);
      rchk("reduced", IDX_LAST_DATA, 16'hFFFF, 16'h6100);
      apb(1'b1, IDX_CONTROL, CTR_RESET);
      $display("test modes done");
      // Restart flag and its masked interrupt
      apb(1'b0, IDX_STATUS, 16'h0000);
      i_rdsd_demod_model.pulse_restart();
      rchk("flags", IDX_STATUS, 16'h00E0, 16'h0020);
      rchk("irq status", IDX_IRQ_STATUS, 16'h0004, 16'h0004);
      apb(1'b1, IDX_IRQ_MASK, 16'h0004);
      @(posedge clk);
      #1;
      chk("irq", 16'h0001, {15'h0000, irq});
      apb(1'b1, IDX_IRQ_STATUS, 16'h0004);
      @(posedge clk);
      #1;
      chk("irq", 16'h0000, {15'h0000, irq});
      $display("test restart done");
      // Type E blocks rejected, then accepted, counted from zero
      i_rdsd_demod_model.pulse_restart();
      repeat (3) i_rdsd_demod_model.send(16'h3000, E_IDENT, ERR_NONE);
      apb(1'b1, IDX_SETTINGS, SET_RESET | 16'h0040);
      repeat (4) i_rdsd_demod_model.send(16'h4000, E_IDENT, ERR_NONE);
      rchk("counters", IDX_COUNTERS, 16'hFFFF, 16'h0030);
      $display("test counters done");
      // New-sync command drops lock; relock, then a bad-block limit of two drops it
      apb(1'b1, IDX_CONTROL, 16'h0120);
      repeat (4) @(posedge clk);
      rchk("new sync", IDX_STATUS, 16'h0080, 16'h0000);
      apb(1'b1, IDX_SETTINGS, 16'h1002);
      i_rdsd_demod_model.send(16'h5000, A_IDENT, ERR_NONE);
      rchk("relock", IDX_STATUS, 16'h0080, 16'h0080);
      repeat (2) i_rdsd_demod_model.send(16'h5000, A_IDENT, ERR_UNCORR);
      repeat (4) @(posedge clk);
      rchk("sync", IDX_STATUS, 16'h0080, 16'h0000);
      rchk("irq status", IDX_IRQ_STATUS, 16'h0008, 16'h0008);
      $display("test loss done");
      test_done();
   end
endmodule
